// [design/bsi_pkg.sv]
// Purpose: shared constants for the bus shutdown and irq config block
// Assumes: apb with 32-bit data, 40 MHz pclk
// Notes: offsets are byte addresses of aligned words
package bsi_pkg;
	localparam logic [7:0] CFG_OFF = 8'h00;
	localparam logic [7:0] RTC_OFF = 8'h04;
	localparam logic [7:0] SEL_A_OFF = 8'h08;
	localparam logic [7:0] SEL_B_OFF = 8'h0c;
	localparam logic [7:0] BITW_OFF = 8'h10;
	localparam logic [7:0] STS_OFF = 8'h14;
	localparam logic [7:0] MASK_OFF = 8'h18;
	localparam int CFG_RT_EN_BIT = 6;
	localparam int CFG_TXO_BIT = 3;
	localparam int CFG_ITYPE_BIT = 2;
	localparam logic [15:0] CFG_WR_MASK = 16'h004c;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam int RTC_INH_A_BIT = 0;
	localparam int RTC_INH_B_BIT = 1;
	localparam int RTC_MANUAL_BIT = 2;
	localparam logic [15:0] RTC_WR_MASK = 16'h0007;
	localparam logic [15:0] RTC_RESET = 16'h0000;
	localparam logic [15:0] SEL_RESET = 16'h0000;
	localparam int N_EV = 3;
	localparam int EV_SHUTDOWN = 0;
	localparam int EV_OVERRIDE = 1;
	localparam int EV_HOST_ACT = 2;
	localparam logic [N_EV-1:0] EV_RESET = 3'h0;
	localparam logic [4:0] MC_SHUTDOWN = 5'h04;
	localparam logic [4:0] MC_OVERRIDE = 5'h05;
	localparam logic [4:0] MC_SEL_SHUTDOWN = 5'h14;
	localparam logic [4:0] MC_SEL_OVERRIDE = 5'h15;
	localparam int CLK_PERIOD_NS = 25;
	localparam int IRQ_PULSE_NS = 1000;
	localparam int ACK_MIN_NS = 250;
	localparam int IRQ_PULSE_CYC_I = IRQ_PULSE_NS / CLK_PERIOD_NS;
	localparam int ACK_MIN_CYC_I = (ACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] IRQ_PULSE_CYC = 8'(IRQ_PULSE_CYC_I);
	localparam logic [7:0] ACK_MIN_CYC = 8'(ACK_MIN_CYC_I);
	typedef enum logic [1:0] {
		BSI_IRQ_IDLE = 2'b00,
		BSI_IRQ_PULSE = 2'b01,
		BSI_IRQ_HOLD = 2'b10
	} bsi_irq_state_t;
endpackage

// [design/bsi_irq_shaper.sv]
// Purpose: shapes the active-low interrupt request pin
// Assumes: ack input synchronous to pclk
// Notes: pulse mode retriggers on a new event
`timescale 1ns/1ps
`default_nettype none
module bsi_irq_shaper (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq_event,
	input wire logic level_mode,
	input wire logic interrupt_acknowledge_in,
	output logic irq_req_n
);
	localparam int PULSE_LEN = bsi_pkg::IRQ_PULSE_CYC_I;
	bsi_pkg::bsi_irq_state_t state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [7:0] ack_cnt_r, ack_cnt_nxt;
	wire ack_done = interrupt_acknowledge_in && (ack_cnt_r >= bsi_pkg::ACK_MIN_CYC - 8'h01);
	wire ack_sat = ack_cnt_r == bsi_pkg::ACK_MIN_CYC;
	assign ack_cnt_nxt = !interrupt_acknowledge_in ? 8'h00 : (ack_sat ? ack_cnt_r : ack_cnt_r + 8'h01);
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			bsi_pkg::BSI_IRQ_IDLE: begin
				if (irq_event) begin
					state_nxt = level_mode ? bsi_pkg::BSI_IRQ_HOLD : bsi_pkg::BSI_IRQ_PULSE; // [R08] [R09]
					cnt_nxt = bsi_pkg::IRQ_PULSE_CYC - 8'h01;
				end
			end
			bsi_pkg::BSI_IRQ_PULSE: begin
				if (irq_event) begin
					cnt_nxt = bsi_pkg::IRQ_PULSE_CYC - 8'h01;
				end else if (cnt_r == 8'h00) begin
					state_nxt = bsi_pkg::BSI_IRQ_IDLE; // [R08]
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			bsi_pkg::BSI_IRQ_HOLD: begin
				// a fresh event beats a release in the same cycle
				if (ack_done && !irq_event) begin
					state_nxt = bsi_pkg::BSI_IRQ_IDLE; // [R10]
				end
			end
			default: begin
				state_nxt = bsi_pkg::BSI_IRQ_IDLE;
			end
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= bsi_pkg::BSI_IRQ_IDLE;
			cnt_r <= 8'h00;
			ack_cnt_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			ack_cnt_r <= ack_cnt_nxt;
		end
	end
	assign irq_req_n = state_r == bsi_pkg::BSI_IRQ_IDLE;
	// check helper: cycles since the last event while pulsing, kept apart from cnt_r
	logic [7:0] pulse_age_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_age_r <= 8'h00;
		end else if (irq_event) begin
			pulse_age_r <= 8'h01;
		end else if (state_r == bsi_pkg::BSI_IRQ_PULSE) begin
			pulse_age_r <= pulse_age_r + 8'h01;
		end else begin
			pulse_age_r <= 8'h00;
		end
	end
	wire pulse_end = state_r == bsi_pkg::BSI_IRQ_PULSE && pulse_age_r == 8'(PULSE_LEN);
	wire pulse_young = state_r == bsi_pkg::BSI_IRQ_PULSE && pulse_age_r < 8'(PULSE_LEN);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_pulse_low: assert property ($rose(state_r == bsi_pkg::BSI_IRQ_PULSE) |-> !irq_req_n [*8]) // [R08]
		else $error("irq pulse shorter than expected");
	chk_pulse_len: assert property ((pulse_end && !irq_event) |=> irq_req_n) // [R08]
		else $error("irq pulse length wrong");
	chk_pulse_short: assert property (pulse_young |=> !irq_req_n) // [R08]
		else $error("irq pulse ended early");
	chk_level_hold: assert property ((state_r == bsi_pkg::BSI_IRQ_HOLD && !interrupt_acknowledge_in)
		|=> !irq_req_n) // [R09]
		else $error("level irq released without ack");
	chk_ack_min: assert property (($rose(irq_req_n) && $past(state_r) == bsi_pkg::BSI_IRQ_HOLD)
		|-> $past(interrupt_acknowledge_in, 10)) // [R10]
		else $error("level irq released by short ack");
	cov_pulse: cover property ($rose(state_r == bsi_pkg::BSI_IRQ_PULSE) ##[1:PULSE_LEN] irq_req_n);
	cov_level_ack: cover property (state_r == bsi_pkg::BSI_IRQ_HOLD ##[1:40] irq_req_n);
endmodule
`default_nettype wire

// [design/bsi_core.sv]
// Purpose: bus shutdown handling and irq pin shaping of a remote terminal
// Assumes: apb slave, zero wait, mode commands decoded upstream
// Notes: one mode command per mc_valid pulse
// Behaviour
// [R01] transmit-only choice and all inhibits act only while terminal enabled
// [R02] transmit-only clear: inhibit or auto shutdown blocks both directions
// [R03] transmit-only set: inhibited bus still receives, sends no responses
// [R04] terminal executes shutdown and override mode commands by itself
// [R05] manual flag set: selected shutdown commands left for host inhibit bits
// [R06] manual flag clear: mode data matched to bus select, then applied
// [R07] auto shutdown leaves host bits, reports state in top bits of bit word
// [R08] pulse mode: each enabled event gives one 1 us low pulse; an event during a pulse restarts the 1 us count instead
// [R09] level mode: request pin held low until host acknowledges
// [R10] host holds acknowledge at least 250 ns to release request
// [R11] config bits 1 and 0 always read zero
// [R12] transmit-only and output type bits read/write, zero after reset
`timescale 1ns/1ps
`default_nettype none
module bsi_core #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mc_valid,
	input wire logic [4:0] mc_code,
	input wire logic mc_bus,
	input wire logic [15:0] mc_data,
	input wire logic interrupt_acknowledge_in,
	output logic [1:0] tx_inhibit,
	output logic [1:0] rx_inhibit,
	output logic irq,
	output logic irq_req_n
);
	logic [15:0] cfg_r, cfg_nxt;
	logic [15:0] rtc_r, rtc_nxt;
	logic [1:0][15:0] sel_r;
	logic [1:0] sd_r;
	logic [bsi_pkg::N_EV-1:0] sts_r, sts_nxt;
	logic [bsi_pkg::N_EV-1:0] mask_r, mask_nxt;
	logic [31:0] prdata_r;

	// apb decode
	wire [7:0] addr8 = paddr[7:0];
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_cfg = addr8 == bsi_pkg::CFG_OFF;
	wire hit_rtc = addr8 == bsi_pkg::RTC_OFF;
	wire hit_sel_a = addr8 == bsi_pkg::SEL_A_OFF;
	wire hit_sel_b = addr8 == bsi_pkg::SEL_B_OFF;
	wire hit_bitw = addr8 == bsi_pkg::BITW_OFF;
	wire hit_sts = addr8 == bsi_pkg::STS_OFF;
	wire hit_mask = addr8 == bsi_pkg::MASK_OFF;
	wire hit_hi = (ADDR_W > 8) ? (paddr >> 8) == '0 : 1'b1;
	wire mapped = hit_hi && (hit_cfg || hit_rtc || hit_sel_a || hit_sel_b
		|| hit_bitw || hit_sts || hit_mask);
	wire wr = access && pwrite && mapped;
	wire wr_cfg = wr && hit_cfg;
	wire wr_rtc = wr && hit_rtc;
	wire [1:0] wr_sel = {wr && hit_sel_b, wr && hit_sel_a};
	wire wr_sts = wr && hit_sts;
	wire wr_mask = wr && hit_mask;

	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// configuration fields
	wire rt_en = cfg_r[bsi_pkg::CFG_RT_EN_BIT];
	wire txo = cfg_r[bsi_pkg::CFG_TXO_BIT];
	wire level_mode = cfg_r[bsi_pkg::CFG_ITYPE_BIT];
	wire [1:0] host_inh = {rtc_r[bsi_pkg::RTC_INH_B_BIT], rtc_r[bsi_pkg::RTC_INH_A_BIT]};
	wire manual = rtc_r[bsi_pkg::RTC_MANUAL_BIT];

	// only writable bits are stored, so reserved bits read back zero
	assign cfg_nxt = wr_cfg ? (pwdata[15:0] & bsi_pkg::CFG_WR_MASK) : cfg_r; // [R11] [R12]
	assign rtc_nxt = wr_rtc ? (pwdata[15:0] & bsi_pkg::RTC_WR_MASK) : rtc_r;
	assign mask_nxt = wr_mask ? pwdata[bsi_pkg::N_EV-1:0] : mask_r;

	// mode command classification
	wire mc_ok = mc_valid && rt_en;
	wire mc4 = mc_ok && mc_code == bsi_pkg::MC_SHUTDOWN;
	wire mc5 = mc_ok && mc_code == bsi_pkg::MC_OVERRIDE;
	wire mc20 = mc_ok && mc_code == bsi_pkg::MC_SEL_SHUTDOWN;
	wire mc21 = mc_ok && mc_code == bsi_pkg::MC_SEL_OVERRIDE;
	wire [1:0] sd_set;
	wire [1:0] sd_clr;
	wire [1:0] sd_tx;
	wire [1:0] sd_rx;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_bus
			wire other = mc_bus != 1'(i);
			wire match = mc_data == sel_r[i];
			// mc4/mc5 hit the bus the command did not arrive on
			assign sd_set[i] = (mc4 && other) || (mc20 && !manual && match); // [R04] [R05] [R06]
			assign sd_clr[i] = (mc5 && other) || (mc21 && !manual && match); // [R04] [R05] [R06]
			wire inh = host_inh[i] || sd_r[i];
			assign tx_inhibit[i] = rt_en && inh; // [R01] [R02] [R03]
			assign rx_inhibit[i] = rt_en && inh && !txo; // [R01] [R02] [R03]
			assign sd_tx[i] = rt_en && sd_r[i]; // [R07]
			assign sd_rx[i] = rt_en && sd_r[i] && !txo; // [R07]
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sd_r[i] <= 1'b0;
					sel_r[i] <= bsi_pkg::SEL_RESET;
				end else begin
					// shutdown state is kept apart from the host inhibit bits
					if (sd_set[i]) begin
						sd_r[i] <= 1'b1; // [R04] [R06] [R07]
					end else if (sd_clr[i]) begin
						sd_r[i] <= 1'b0; // [R04] [R06]
					end
					if (wr_sel[i]) begin
						sel_r[i] <= pwdata[15:0];
					end
				end
			end
		end
	endgenerate

	// status top bits: tx a, rx a, tx b, rx b
	wire [15:0] bitw = {sd_tx[0], sd_rx[0], sd_tx[1], sd_rx[1], 12'h000}; // [R07]

	// events, set wins over a same-cycle write-one-to-clear
	wire [bsi_pkg::N_EV-1:0] ev;
	assign ev[bsi_pkg::EV_SHUTDOWN] = |sd_set;
	assign ev[bsi_pkg::EV_OVERRIDE] = |sd_clr;
	assign ev[bsi_pkg::EV_HOST_ACT] = manual && (mc20 || mc21); // [R05]
	wire [bsi_pkg::N_EV-1:0] sts_clr = wr_sts ? pwdata[bsi_pkg::N_EV-1:0] : '0;
	assign sts_nxt = (sts_r & ~sts_clr) | ev;
	assign irq = |(sts_r & mask_r);
	wire irq_event = |(ev & mask_r);

	// read data is captured in setup so prdata comes from a flop
	wire [15:0] rd16 = hit_cfg ? cfg_r
		: hit_rtc ? rtc_r
		: hit_sel_a ? sel_r[0]
		: hit_sel_b ? sel_r[1]
		: hit_bitw ? bitw
		: hit_sts ? 16'(sts_r)
		: hit_mask ? 16'(mask_r)
		: 16'h0000;
	wire [31:0] rd_mux = (mapped && !pwrite) ? {16'h0000, rd16} : 32'h0000_0000;
	assign prdata = prdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= bsi_pkg::CFG_RESET; // [R12]
			rtc_r <= bsi_pkg::RTC_RESET;
			sts_r <= bsi_pkg::EV_RESET;
			mask_r <= bsi_pkg::EV_RESET;
			prdata_r <= 32'h0000_0000;
		end else begin
			cfg_r <= cfg_nxt;
			rtc_r <= rtc_nxt;
			sts_r <= sts_nxt;
			mask_r <= mask_nxt;
			if (setup) begin
				prdata_r <= rd_mux;
			end
		end
	end

	bsi_irq_shaper u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.irq_event(irq_event),
		.level_mode(level_mode),
		.interrupt_acknowledge_in(interrupt_acknowledge_in),
		.irq_req_n(irq_req_n)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_disabled_open: assert property (!rt_en |-> (tx_inhibit == 2'b00 && rx_inhibit == 2'b00)) // [R01]
		else $error("inhibit active while terminal disabled");
	chk_both_block: assert property ((rt_en && !txo && host_inh[0]) |-> (tx_inhibit[0] && rx_inhibit[0])) // [R02]
		else $error("bus a not fully blocked");
	chk_txo_receive: assert property ((rt_en && txo && sd_r[1]) |-> (tx_inhibit[1] && !rx_inhibit[1])) // [R03]
		else $error("transmit-only shutdown blocked receive");
	chk_mc4_apply: assert property ((mc_valid && rt_en && mc_code == bsi_pkg::MC_SHUTDOWN && !mc_bus)
		|=> (sd_r[1] && tx_inhibit[1])) // [R04]
		else $error("shutdown command not applied to bus b");
	chk_mc5_apply: assert property ((mc_valid && rt_en && mc_code == bsi_pkg::MC_OVERRIDE && mc_bus)
		|=> !sd_r[0]) // [R04]
		else $error("override command not applied to bus a");
	chk_manual_skip: assert property ((mc_valid && rt_en && manual && mc_code == bsi_pkg::MC_SEL_SHUTDOWN)
		|=> ($stable(sd_r) && sts_r[bsi_pkg::EV_HOST_ACT])) // [R05]
		else $error("selected shutdown acted on in manual mode");
	chk_sel_match: assert property ((mc_valid && rt_en && !manual && mc_code == bsi_pkg::MC_SEL_SHUTDOWN
		&& mc_data == sel_r[0]) |=> sd_r[0]) // [R06]
		else $error("matched selected shutdown not applied");
	chk_sel_nomatch: assert property ((mc_valid && !manual && mc_code == bsi_pkg::MC_SEL_SHUTDOWN
		&& mc_data != sel_r[1] && !sd_r[1]) |=> !sd_r[1]) // [R06]
		else $error("unmatched selected shutdown applied");
	chk_host_bits: assert property ((mc_valid && !wr_rtc) |=> $stable(rtc_r)) // [R07]
		else $error("auto shutdown changed host inhibit bits");
	chk_bit_word: assert property ((setup && hit_bitw && !pwrite) |=> prdata[15] == $past(sd_tx[0])
		&& prdata[12] == $past(sd_rx[1])) // [R07]
		else $error("bit word shutdown status wrong");
	chk_cfg_reserved: assert property ((setup && hit_cfg && !pwrite) |=> prdata[1:0] == 2'b00) // [R11]
		else $error("config reserved bits not zero");
	chk_cfg_rw: assert property (wr_cfg |=> (txo == $past(pwdata[bsi_pkg::CFG_TXO_BIT])
		&& level_mode == $past(pwdata[bsi_pkg::CFG_ITYPE_BIT]))) // [R12]
		else $error("config bits not written");

	cov_mc4: cover property (mc4 ##1 tx_inhibit != 2'b00);
	cov_sel_auto: cover property (mc20 && !manual && |sd_set);
	cov_txo: cover property (rt_en && txo && |tx_inhibit);
endmodule
`default_nettype wire

// [tb/bsi_bc_model.sv]
// Purpose: bus controller stand-in that issues decoded mode commands
// Assumes: one command per call, one cycle valid pulse
// Notes: idle lines carry inverted values so stale data is never trusted
`timescale 1ns/1ps
`default_nettype none
module bsi_bc_model (
	input wire logic pclk,
	output logic mc_valid,
	output logic [4:0] mc_code,
	output logic mc_bus,
	output logic [15:0] mc_data
);
	initial begin
		mc_valid = 1'b0;
		mc_code = 5'h1f;
		mc_bus = 1'b0;
		mc_data = 16'hffff;
	end
	task automatic send(input logic [4:0] c, input logic b, input logic [15:0] d);
		@(posedge pclk);
		mc_valid <= 1'b1;
		mc_code <= c;
		mc_bus <= b;
		mc_data <= d;
		@(posedge pclk);
		mc_valid <= 1'b0;
		mc_code <= ~c;
		mc_bus <= ~b;
		mc_data <= ~d;
	endtask
endmodule
`default_nettype wire

// [tb/bsi_core_test.sv]
// Purpose: self-checking bench for the bus shutdown and irq block
// Assumes: zero or more wait states, apb driven on rising edges
// Notes: pin timing judged at falling edges, where outputs are settled
`timescale 1ns/1ps
`default_nettype none
module bsi_core_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic irq, irq_req_n, ack, mc_valid, mc_bus;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] mc_code;
	logic [15:0] mc_data;
	logic [1:0] tx_inhibit, rx_inhibit;
	int failures, total_checks, cycles;
	bsi_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mc_valid(mc_valid), .mc_code(mc_code),
		.mc_bus(mc_bus), .mc_data(mc_data), .interrupt_acknowledge_in(ack),
		.tx_inhibit(tx_inhibit), .rx_inhibit(rx_inhibit), .irq(irq), .irq_req_n(irq_req_n));
	bsi_bc_model i_bc (.pclk(pclk), .mc_valid(mc_valid), .mc_code(mc_code),
		.mc_bus(mc_bus), .mc_data(mc_data));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until pready is sampled high; the timeout ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 16'h0000);
		chk(rd, exp);
	endtask
	task automatic inh(input logic [1:0] t, input logic [1:0] r);
		@(negedge pclk);
		chk({28'h000_0000, tx_inhibit, rx_inhibit}, {28'h000_0000, t, r});
	endtask
	task automatic ack_for(input int k);
		@(posedge pclk);
		ack <= 1'b1;
		repeat (k) @(posedge pclk);
		ack <= 1'b0;
		repeat (2) @(negedge pclk);
	endtask
	task automatic t_regs();
		rdchk(bsi_pkg::CFG_OFF, 32'h0000_0000);
		chk({31'h0000_0000, err}, 32'h0000_0000);
		chk({31'h0000_0000, pready}, 32'h0000_0001);
		wr(bsi_pkg::CFG_OFF, 16'hffff);
		rdchk(bsi_pkg::CFG_OFF, 32'h0000_004c);
		rdchk(8'h40, 32'h0000_0000);
		chk({31'h0000_0000, err}, 32'h0000_0001);
		wr(bsi_pkg::CFG_OFF, 16'h0008);
		$display("test regs done");
	endtask
	task automatic t_inh();
		wr(bsi_pkg::RTC_OFF, 16'h0001);
		inh(2'b00, 2'b00);
		wr(bsi_pkg::CFG_OFF, 16'h0040);
		inh(2'b01, 2'b01);
		wr(bsi_pkg::CFG_OFF, 16'h0048);
		inh(2'b01, 2'b00);
		wr(bsi_pkg::RTC_OFF, 16'h0000);
		wr(bsi_pkg::CFG_OFF, 16'h0040);
		$display("test inhibit done");
	endtask
	task automatic t_auto();
		i_bc.send(bsi_pkg::MC_SHUTDOWN, 1'b0, 16'h0000);
		inh(2'b10, 2'b10);
		chk({31'h0000_0000, irq_req_n}, 32'h0000_0001);
		rdchk(bsi_pkg::RTC_OFF, 32'h0000_0000);
		rdchk(bsi_pkg::BITW_OFF, 32'h0000_3000);
		i_bc.send(bsi_pkg::MC_OVERRIDE, 1'b0, 16'h0000);
		inh(2'b00, 2'b00);
		wr(bsi_pkg::CFG_OFF, 16'h0048);
		i_bc.send(bsi_pkg::MC_SHUTDOWN, 1'b1, 16'h0000);
		inh(2'b01, 2'b00);
		rdchk(bsi_pkg::BITW_OFF, 32'h0000_8000);
		i_bc.send(bsi_pkg::MC_OVERRIDE, 1'b1, 16'h0000);
		wr(bsi_pkg::CFG_OFF, 16'h0040);
		rdchk(bsi_pkg::STS_OFF, 32'h0000_0003);
		wr(bsi_pkg::STS_OFF, 16'h0003);
		rdchk(bsi_pkg::STS_OFF, 32'h0000_0000);
		$display("test auto done");
	endtask
	task automatic t_sel();
		wr(bsi_pkg::SEL_A_OFF, 16'h1234);
		wr(bsi_pkg::SEL_B_OFF, 16'h5678);
		i_bc.send(bsi_pkg::MC_SEL_SHUTDOWN, 1'b0, 16'h0001);
		inh(2'b00, 2'b00);
		i_bc.send(bsi_pkg::MC_SEL_SHUTDOWN, 1'b0, 16'h5678);
		inh(2'b10, 2'b10);
		i_bc.send(bsi_pkg::MC_SEL_SHUTDOWN, 1'b1, 16'h1234);
		inh(2'b11, 2'b11);
		i_bc.send(bsi_pkg::MC_SEL_OVERRIDE, 1'b1, 16'h5678);
		inh(2'b01, 2'b01);
		i_bc.send(bsi_pkg::MC_SEL_OVERRIDE, 1'b0, 16'h1234);
		inh(2'b00, 2'b00);
		wr(bsi_pkg::RTC_OFF, 16'h0004);
		i_bc.send(bsi_pkg::MC_SEL_SHUTDOWN, 1'b0, 16'h1234);
		inh(2'b00, 2'b00);
		rdchk(bsi_pkg::STS_OFF, 32'h0000_0007);
		wr(bsi_pkg::RTC_OFF, 16'h0005);
		inh(2'b01, 2'b01);
		wr(bsi_pkg::RTC_OFF, 16'h0000);
		wr(bsi_pkg::STS_OFF, 16'h0007);
		$display("test select done");
	endtask
	task automatic t_irq();
		int n;
		n = 0;
		wr(bsi_pkg::MASK_OFF, 16'h0001);
		i_bc.send(bsi_pkg::MC_SHUTDOWN, 1'b0, 16'h0000);
		@(negedge pclk);
		while (irq_req_n === 1'b0 && n < 60) begin
			n++;
			@(negedge pclk);
		end
		chk(n, 32'd40);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		wr(bsi_pkg::STS_OFF, 16'h0001);
		// the clear lands on the access edge, so look once it has settled
		@(negedge pclk);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		wr(bsi_pkg::CFG_OFF, 16'h0044);
		i_bc.send(bsi_pkg::MC_SHUTDOWN, 1'b0, 16'h0000);
		repeat (60) @(negedge pclk);
		chk({31'h0000_0000, irq_req_n}, 32'h0000_0000);
		ack_for(9);
		chk({31'h0000_0000, irq_req_n}, 32'h0000_0000);
		ack_for(10);
		chk({31'h0000_0000, irq_req_n}, 32'h0000_0001);
		i_bc.send(bsi_pkg::MC_OVERRIDE, 1'b0, 16'h0000);
		wr(bsi_pkg::STS_OFF, 16'h0003);
		$display("test irq done");
	endtask
	// ceiling well above the few hundred cycles the tests need
	initial begin
		cycles = 0;
		forever begin
			@(posedge pclk);
			cycles++;
			if (cycles == 8000) begin
				failures++;
				end_sim();
			end
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		ack = 1'b0;
		failures = 0;
		total_checks = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_inh();
		t_auto();
		t_sel();
		t_irq();
		end_sim();
	end
endmodule
`default_nettype wire
